// [qerm_pkg.sv]
// package of constants and types for the quadword check-code read-merge-write path
// Behaviour
// - ecc mode input selects check-code processing; otherwise data passes unprotected.
// - in ecc mode each 64-bit quadword gets one 8-bit check code stored beside it; plain writes store a zero code.
// - in ecc mode every memory write is a full quadword with its code.
// - partial writes in ecc mode become a read-merge-write on the quadword.
// - order: read quadword, merge new bytes, recompute code, write back.
// - a single-bit error found during the merge read is fixed before merging.
// - decoding corrects single-bit errors and detects double-bit errors.
package qerm_pkg;
  localparam int DATA_W  = 64;
  localparam int CODE_W  = 8;
  localparam int BYTES_W = 8;
  localparam int ADDR_W  = 32;
  localparam logic [BYTES_W-1:0] FULL_MASK = 8'hFF;
  typedef logic [DATA_W-1:0] qerm_data_t;
  typedef logic [CODE_W-1:0] qerm_code_t;
  typedef enum logic [1:0] {QERM_IDLE, QERM_RD, QERM_WAIT, QERM_WR} qerm_state_e;
endpackage

// [qerm_code_if.sv]
// interface carrying a read quadword with its check code, a write quadword with its new code, and the decode result
`timescale 1ns/1ps
interface qerm_code_if;
  import qerm_pkg::*;
  qerm_data_t raw_data;
  qerm_code_t raw_code;
  qerm_data_t wr_data;
  qerm_code_t wr_code;
  qerm_data_t fixed_data;
  logic       single_err;
  logic       double_err;
  modport user  (output raw_data, raw_code, wr_data, input wr_code, fixed_data, single_err, double_err);
  modport coder (input raw_data, raw_code, wr_data, output wr_code, fixed_data, single_err, double_err);
endinterface

// [qerm_secded.sv]
// single-error-correct double-error-detect coder over one quadword
`timescale 1ns/1ps
module qerm_secded (
  qerm_code_if.coder cif
);
  import qerm_pkg::*;

  // hamming position for data bit i: skip powers of two, positions 3..71
  function automatic logic [6:0] dpos(input int i);
    int p;
    int k;
    p = 0;
    k = -1;
    while (k < i) begin
      p = p + 1;
      if ((p & (p - 1)) != 0) begin
        k = k + 1;
      end
    end
    return p[6:0];
  endfunction

  function automatic qerm_code_t encode(input qerm_data_t d);
    logic [6:0] s;
    logic       par;
    s = 7'h00;
    for (int i = 0; i < DATA_W; i++) begin
      if (d[i]) begin
        s = s ^ dpos(i);
      end
    end
    par = ^d ^ ^s;
    return {par, s};
  endfunction

  logic [6:0] syn;
  logic       par_bad;
  qerm_code_t recode;

  always_comb begin
    recode  = encode(cif.raw_data);
    syn     = recode[6:0] ^ cif.raw_code[6:0];
    par_bad = ^cif.raw_data ^ ^cif.raw_code;
  end

  assign cif.wr_code    = encode(cif.wr_data);
  assign cif.single_err = par_bad;
  assign cif.double_err = !par_bad && (syn != 7'h00);

  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_fix
      assign cif.fixed_data[g] = cif.raw_data[g] ^ (par_bad && syn == dpos(g));
    end
  endgenerate
endmodule // qerm_secded

// [qerm_top.sv]
// read-merge-write controller placing check codes beside each memory quadword in ecc mode, a zero code otherwise
`timescale 1ns/1ps
module qerm_top (
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  input  wire logic                     ecc_mode,
  input  wire logic                     req_valid,
  input  wire logic                     req_write,
  input  wire logic [qerm_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [qerm_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic [qerm_pkg::BYTES_W-1:0] req_be,
  output logic                          req_ready,
  output logic                          rsp_valid,
  output logic [qerm_pkg::DATA_W-1:0]   rsp_rdata,
  output logic                          mem_rd,
  output logic                          mem_wr,
  output logic [qerm_pkg::ADDR_W-1:0]   mem_addr,
  output logic [qerm_pkg::DATA_W-1:0]   mem_wdata,
  output logic [qerm_pkg::CODE_W-1:0]   mem_wcode,
  output logic [qerm_pkg::BYTES_W-1:0]  mem_be,
  input  wire logic                     mem_rvalid,
  input  wire logic [qerm_pkg::DATA_W-1:0]  mem_rdata,
  input  wire logic [qerm_pkg::CODE_W-1:0]  mem_rcode,
  input  wire logic                     err_clear,
  output logic                          corr_err,
  output logic                          uncorr_err
);
  import qerm_pkg::*;

  qerm_code_if cif ();
  qerm_secded u_coder (
    .cif (cif)
  );

  qerm_state_e            state;
  logic                   is_wr;
  logic                   ecc_q;
  logic [ADDR_W-1:0]      addr_q;
  qerm_data_t             wdata_q;
  logic [BYTES_W-1:0]     be_q;
  qerm_data_t             merged;
  qerm_data_t             rd_fixed;
  logic                   corr_evt;
  logic                   unc_evt;

  always_comb begin
    rd_fixed = ecc_q ? cif.fixed_data : mem_rdata;
    for (int b = 0; b < BYTES_W; b++) begin
      merged[b*8 +: 8] = be_q[b] ? wdata_q[b*8 +: 8] : rd_fixed[b*8 +: 8];
    end
  end

  assign cif.raw_data = mem_rdata;
  assign cif.raw_code = mem_rcode;
  assign cif.wr_data  = (state == QERM_WAIT) ? merged : wdata_q;
  assign corr_evt = (state == QERM_WAIT) && mem_rvalid && ecc_q && cif.single_err;
  assign unc_evt  = (state == QERM_WAIT) && mem_rvalid && ecc_q && cif.double_err;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= QERM_IDLE;
      is_wr     <= 1'b0;
      ecc_q     <= 1'b0;
      addr_q    <= '0;
      wdata_q   <= '0;
      be_q      <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      mem_wcode <= '0;
      mem_be    <= '0;
    end else begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      case (state)
        QERM_IDLE: begin
          if (req_valid && !req_ready) begin
            req_ready <= 1'b1;
            is_wr     <= req_write;
            ecc_q     <= ecc_mode;
            addr_q    <= req_addr;
            wdata_q   <= req_wdata;
            be_q      <= req_be;
            if (req_write && (!ecc_mode || req_be == FULL_MASK)) begin
              state <= QERM_WR;
            end else begin
              state <= QERM_RD;
            end
          end
        end
        QERM_RD: begin
          mem_rd   <= 1'b1;
          mem_addr <= addr_q;
          mem_be   <= FULL_MASK;
          state    <= QERM_WAIT;
        end
        QERM_WAIT: begin
          if (mem_rvalid) begin
            if (is_wr) begin
              mem_wr    <= 1'b1;
              mem_addr  <= addr_q;
              mem_wdata <= merged;
              mem_wcode <= cif.wr_code;
              mem_be    <= FULL_MASK;
              rsp_valid <= 1'b1;
              state     <= QERM_IDLE;
            end else begin
              rsp_valid <= 1'b1;
              rsp_rdata <= rd_fixed;
              state     <= QERM_IDLE;
            end
          end
        end
        QERM_WR: begin
          mem_wr    <= 1'b1;
          mem_addr  <= addr_q;
          mem_wdata <= wdata_q;
          mem_wcode <= ecc_q ? cif.wr_code : '0;
          mem_be    <= ecc_q ? FULL_MASK : be_q;
          rsp_valid <= 1'b1;
          state     <= QERM_IDLE;
        end
        default: state <= QERM_IDLE;
      endcase
    end
  end

  // sticky error flags: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      corr_err   <= 1'b0;
      uncorr_err <= 1'b0;
    end else begin
      corr_err   <= corr_evt | (corr_err & ~err_clear);
      uncorr_err <= unc_evt | (uncorr_err & ~err_clear);
    end
  end
endmodule // qerm_top

// [qerm_props.sv]
// checker of the quadword check-code controller ports
`timescale 1ns/1ps
module qerm_props (
  input wire logic                          ref_clk,
  input wire logic                          arst_n,
  input wire logic                          ecc_mode,
  input wire logic                          req_write,
  input wire logic [qerm_pkg::BYTES_W-1:0] req_be,
  input wire logic [qerm_pkg::DATA_W-1:0]  req_wdata,
  input wire logic                          req_ready,
  input wire logic                          rsp_valid,
  input wire logic                          mem_rd,
  input wire logic                          mem_wr,
  input wire logic [qerm_pkg::DATA_W-1:0]  mem_wdata,
  input wire logic [qerm_pkg::CODE_W-1:0]  mem_wcode,
  input wire logic [qerm_pkg::BYTES_W-1:0] mem_be,
  input wire logic                          mem_rvalid,
  input wire logic                          err_clear,
  input wire logic                          corr_err,
  input wire logic                          uncorr_err
);
  import qerm_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_full_taken;
    req_ready && $past(req_write && ecc_mode && req_be == FULL_MASK);
  endsequence
  sequence s_part_taken;
    req_ready && $past(req_write && ecc_mode && req_be != FULL_MASK);
  endsequence
  chk_full_write: assert property (
    s_full_taken |=> mem_wr && rsp_valid && mem_be == FULL_MASK && mem_wdata == $past(req_wdata, 2))
    else $error("full write not issued directly");
  chk_rmw_start: assert property (s_part_taken |=> mem_rd && !mem_wr)
    else $error("partial write did not start with a read");
  chk_no_early_wr: assert property (mem_rd |=> !mem_wr until mem_rvalid)
    else $error("write before merge read returned");
  chk_rmw_close: assert property (mem_rvalid |=> rsp_valid)
    else $error("no completion after memory data");
  chk_ecc_be: assert property (ecc_mode && mem_wr |-> mem_be == FULL_MASK)
    else $error("ecc write not a full quadword");
  chk_plain_code: assert property (!ecc_mode && mem_wr |-> mem_wcode == 8'h00)
    else $error("code attached outside ecc mode");
  chk_zero_code: assert property (ecc_mode && mem_wr && mem_wdata == '0 |-> mem_wcode == 8'h00)
    else $error("wrong code for zero quadword");
  chk_corr_hold: assert property (corr_err && !err_clear |=> corr_err)
    else $error("corrected flag lost");
  chk_uncorr_clear: assert property (err_clear && !mem_rvalid |=> !uncorr_err)
    else $error("error flag not cleared");
endmodule // qerm_props
bind qerm_top qerm_props i_qerm_props (.*);

// [qerm_mem_model.sv]
// memory model holding quadwords and their check codes
`timescale 1ns/1ps
module qerm_mem_model (
  input  wire logic                          ref_clk,
  input  wire logic                          mem_rd,
  input  wire logic                          mem_wr,
  input  wire logic [qerm_pkg::ADDR_W-1:0]  mem_addr,
  input  wire logic [qerm_pkg::DATA_W-1:0]  mem_wdata,
  input  wire logic [qerm_pkg::CODE_W-1:0]  mem_wcode,
  input  wire logic [qerm_pkg::BYTES_W-1:0] mem_be,
  input  wire logic [3:0]                    lat,
  input  wire logic [qerm_pkg::DATA_W-1:0]  flip,
  output logic                               mem_rvalid,
  output logic [qerm_pkg::DATA_W-1:0]       mem_rdata,
  output logic [qerm_pkg::CODE_W-1:0]       mem_rcode
);
  import qerm_pkg::*;
  qerm_data_t q [16] = '{default: '0};
  qerm_code_t c [16] = '{default: '0};
  logic [3:0] cnt = '0;
  logic [3:0] ra  = '0;
  initial {mem_rvalid, mem_rdata, mem_rcode} = '0;
  always @(posedge ref_clk) begin
    mem_rvalid <= 1'b0;
    // idle lines keep changing so stale data cannot pass
    mem_rdata <= ~mem_rdata;
    mem_rcode <= ~mem_rcode;
    if (mem_wr) begin
      c[mem_addr[6:3]] <= mem_wcode;
      for (int b = 0; b < BYTES_W; b++) if (mem_be[b]) q[mem_addr[6:3]][b*8+:8] <= mem_wdata[b*8+:8];
    end
    if (mem_rd) begin
      cnt <= lat;
      ra <= mem_addr[6:3];
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= q[ra] ^ flip;
        mem_rcode <= c[ra];
      end
    end
  end
endmodule // qerm_mem_model

// [tb.sv]
// self-checking bench of the quadword check-code controller
`timescale 1ns/1ps
module tb;
  import qerm_pkg::*;
  logic ref_clk = 0, arst_n = 0, ecc_mode = 1, req_valid = 0, req_write = 0, err_clear = 0;
  logic mem_rvalid, req_ready, rsp_valid, mem_rd, mem_wr, corr_err, uncorr_err;
  logic [ADDR_W-1:0] req_addr = '0, mem_addr;
  logic [BYTES_W-1:0] req_be = '0, mem_be;
  logic [CODE_W-1:0] mem_wcode, mem_rcode;
  logic [3:0] lat = 4'h1;
  qerm_data_t req_wdata = '0, flip = '0, rsp_rdata, mem_wdata, mem_rdata, got;
  int n_mismatch = 0, n_tests = 0;
  qerm_top i_qerm_top (.*);
  qerm_mem_model i_qerm_mem_model (.*);
  always #50 ref_clk = ~ref_clk;
  task automatic chk(input qerm_data_t g, input qerm_data_t e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input int w, input logic [7:0] a, input qerm_data_t d, input logic [7:0] be);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w[0];
    req_addr <= {24'h0, a};
    req_wdata <= d;
    req_be <= be;
    do @(posedge ref_clk); while (req_ready !== 1'b1 && ++n < 99);
    req_valid <= 1'b0;
    do @(posedge ref_clk); while (rsp_valid !== 1'b1 && ++n < 99);
    got = rsp_rdata;
    if (n >= 99) begin
      n_mismatch++;
      $display("ERROR %0t: handshake timed out", $time);
    end
  endtask
  task automatic clr;
    err_clear <= 1'b1;
    @(posedge ref_clk);
    err_clear <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_plain;
    ecc_mode <= 1'b0;
    flip <= 64'h10;
    xfer(1, 8'h10, 64'hFEDCBA9876543210, 8'hFF);
    xfer(1, 8'h10, 64'h0000000000000055, 8'h01);
    xfer(0, 8'h10, '0, 8'hFF);
    chk(got, 64'hFEDCBA9876543245);
    flip <= '0;
    ecc_mode <= 1'b1;
  endtask
  task automatic t_full;
    xfer(1, 8'h18, '0, 8'hFF);
    xfer(1, 8'h08, 64'h0123456789ABCDEF, 8'hFF);
    xfer(0, 8'h08, '0, 8'hFF);
    chk(got, 64'h0123456789ABCDEF);
    xfer(1, 8'h08, 64'hFFFFFFFF5555AAAA, 8'h0F);
    xfer(0, 8'h08, '0, 8'hFF);
    chk(got, 64'h012345675555AAAA);
    xfer(0, 8'h18, '0, 8'hFF);
    chk(got, 64'h0);
    chk(64'({corr_err, uncorr_err}), 64'h0);
  endtask
  task automatic t_single;
    lat <= 4'h4;
    flip <= 64'h8;
    xfer(1, 8'h08, 64'h1111222200000000, 8'hF0);
    flip <= '0;
    xfer(0, 8'h08, '0, 8'hFF);
    chk(got, 64'h111122225555AAAA);
    chk(64'(corr_err), 64'h1);
    clr();
    chk(64'(corr_err), 64'h0);
  endtask
  task automatic t_double;
    lat <= 4'h7;
    flip <= 64'h3;
    xfer(0, 8'h08, '0, 8'hFF);
    @(posedge ref_clk);
    chk(64'({corr_err, uncorr_err}), 64'h1);
    clr();
    chk(64'(uncorr_err), 64'h0);
  endtask
  task test_done;
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_plain;
    t_full;
    t_single;
    t_double;
    test_done;
  end
endmodule // tb
